//--- common/ddc_pkg.sv
// Constants, coefficient table and types shared by the downconverter back end
package ddc_pkg;

  // ==========================================================================
  // Datapath widths
  localparam int DW = 16;
  localparam int CW = 21;
  localparam int NTAP = 66;
  localparam int NHALF = 33;
  localparam int PREW = DW + 1;
  localparam int PRODW = PREW + CW;
  localparam int ACCW = PRODW + 6;
  localparam int FIR_SHIFT = 21;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_SLACK = 4;

  // ==========================================================================
  // Configuration port
  localparam int AW = 12;
  localparam int RW = 8;
  localparam logic [AW-1:0] ADDR_SYNC_CTRL = 12'h100;
  localparam logic [AW-1:0] ADDR_FIR_CTRL = 12'h102;
  localparam logic [AW-1:0] ADDR_HB_CTRL = 12'h103;
  localparam logic [AW-1:0] ADDR_MIX_CTRL = 12'h130;
  localparam logic [AW-1:0] ADDR_STATUS = 12'h131;
  localparam int SYNC_EVERY_BIT = 5;
  localparam int SYNC_FIRST_BIT = 6;
  localparam int FIR_EN_BIT = 0;
  localparam int DEC_PHASE_BIT = 3;
  localparam int MIX_EN_BIT = 0;
  localparam int ST_ARMED_BIT = 0;
  localparam int ST_EMPTY_BIT = 1;
  localparam int ST_FULL_BIT = 2;
  localparam logic [RW-1:0] CTRL_RESET = 8'h00;

  // ==========================================================================
  // Half of the symmetric FIR coefficient set, outer tap first
  localparam logic signed [CW-1:0] FIR_COEF [NHALF] = '{
    21'sd383, 21'sd1431, 21'sd1950, 21'sd96, -21'sd2661, -21'sd1750,
    21'sd2476, 21'sd2388, -21'sd3867, -21'sd5150, 21'sd3788, 21'sd7513,
    -21'sd4511, -21'sd11914, 21'sd3650, 21'sd16484, -21'sd2818, -21'sd23200,
    -21'sd48, 21'sd30748, 21'sd3976, -21'sd41019, -21'sd11147, 21'sd53608,
    21'sd21818, -21'sd71611, -21'sd40300, 21'sd98830, 21'sd74264, -21'sd152696,
    -21'sd161248, 21'sd337056, 21'sd922060
  };

  // ==========================================================================
  // Output serialiser states and mixer rotation
  typedef enum logic [0:0] {
    OUT_FIRST = 1'b0,
    OUT_SECOND = 1'b1
  } out_state_t;

  typedef logic [1:0] rot_t;
  localparam rot_t ROT_0 = 2'h0;
  localparam rot_t ROT_90 = 2'h1;
  localparam rot_t ROT_180 = 2'h2;

endpackage

//--- hdl/ddc_fir_sync_final_mixer.sv
// Half-band decimator, 66-tap FIR, sync control, final mixer and output FIFO
`timescale 1ns/10ps
`default_nettype none

// ============================================================================
// Synchronous FIFO
module ddc_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Fill side
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [W-1:0] wrData,
  // Drain side
  output logic rdValid,
  input wire logic rdReady,
  output logic [W-1:0] rdData,
  // Fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW:0] wrPtr_q;
  logic [PW:0] rdPtr_q;
  wire doWr = wrValid & wrReady;
  wire doRd = rdValid & rdReady;

  // Extra pointer bit tells full from empty
  assign level = wrPtr_q - rdPtr_q;
  assign wrReady = (level != (PW + 1)'(DEPTH));
  assign rdValid = (wrPtr_q != rdPtr_q);
  assign rdData = mem[rdPtr_q[PW-1:0]];

  // Storage has no reset, only pointers
  always_ff @(posedge ref_clk)
  begin
    if (doWr)
    begin
      mem[wrPtr_q[PW-1:0]] <= wrData;
    end
  end

  // Pointer update
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end
    else
    begin
      wrPtr_q <= wrPtr_q + (PW + 1)'(doWr);
      rdPtr_q <= rdPtr_q + (PW + 1)'(doRd);
    end
  end
endmodule

// ============================================================================
// Top level
module ddc_fir_sync_final_mixer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Configuration port
  input wire logic [ddc_pkg::AW-1:0] cfgAddr,
  input wire logic [ddc_pkg::RW-1:0] cfgWrData,
  input wire logic cfgWrStb,
  input wire logic cfgRdStb,
  output logic [ddc_pkg::RW-1:0] cfgRdData,
  // Alignment pulse
  input wire logic syncIn,
  // Complex input from the tuning_oscillator
  input wire logic inValid,
  output logic inReady,
  input wire logic signed [ddc_pkg::DW-1:0] inI,
  input wire logic signed [ddc_pkg::DW-1:0] inQ,
  // Output stream
  output logic outValid,
  input wire logic outReady,
  output logic [ddc_pkg::DW-1:0] outData,
  output logic outIsQ
);
  import ddc_pkg::*;

  // ==========================================================================
  // Configuration registers
  logic [RW-1:0] syncCtrl_q;
  logic [RW-1:0] firCtrl_q;
  logic [RW-1:0] hbCtrl_q;
  logic [RW-1:0] mixCtrl_q;
  logic [RW-1:0] rdData_q;
  logic armed_q;
  logic fifoWrReady;
  logic fifoRdValid;

  wire wrSync = cfgWrStb & (cfgAddr == ADDR_SYNC_CTRL);
  wire wrFir = cfgWrStb & (cfgAddr == ADDR_FIR_CTRL);
  wire wrHb = cfgWrStb & (cfgAddr == ADDR_HB_CTRL);
  wire wrMix = cfgWrStb & (cfgAddr == ADDR_MIX_CTRL);
  wire firEn = firCtrl_q[FIR_EN_BIT];
  wire decPhase = hbCtrl_q[DEC_PHASE_BIT];
  wire mixEn = mixCtrl_q[MIX_EN_BIT];
  wire [RW-1:0] statusWord = {{(RW - 3){1'b0}}, ~fifoWrReady, ~fifoRdValid, armed_q};

  // Read decode, unmapped addresses read zero
  wire [RW-1:0] rdMux =
    (cfgAddr == ADDR_SYNC_CTRL) ? syncCtrl_q :
    (cfgAddr == ADDR_FIR_CTRL) ? firCtrl_q :
    (cfgAddr == ADDR_HB_CTRL) ? hbCtrl_q :
    (cfgAddr == ADDR_MIX_CTRL) ? mixCtrl_q :
    (cfgAddr == ADDR_STATUS) ? statusWord : '0;

  // Register writes and one-cycle read data
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      syncCtrl_q <= CTRL_RESET;
      firCtrl_q <= CTRL_RESET;
      hbCtrl_q <= CTRL_RESET;
      mixCtrl_q <= CTRL_RESET;
      rdData_q <= '0;
    end
    else
    begin
      if (wrSync) syncCtrl_q <= cfgWrData;
      if (wrFir) firCtrl_q <= cfgWrData;
      if (wrHb) hbCtrl_q <= cfgWrData;
      if (wrMix) mixCtrl_q <= cfgWrData;
      rdData_q <= cfgRdStb ? rdMux : '0;
    end
  end
  assign cfgRdData = rdData_q;

  // ==========================================================================
  // Sync acceptance
  wire syncAccept = syncIn & (syncCtrl_q[SYNC_EVERY_BIT] | (syncCtrl_q[SYNC_FIRST_BIT] & armed_q));

  // One-shot arm; a write in the same cycle as a pulse re-arms, so it wins
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      armed_q <= 1'b0;
    else if (wrSync)
      armed_q <= 1'b1;
    else if (syncAccept)
      armed_q <= 1'b0;
  end

  // ==========================================================================
  // Half-band decimator, always in the path
  logic inReady_q;
  logic hbCnt_q;
  logic signed [DW-1:0] prevI_q;
  logic signed [DW-1:0] prevQ_q;
  logic signed [DW-1:0] hbI_q;
  logic signed [DW-1:0] hbQ_q;
  logic hbValid_q;

  wire accept = inValid & inReady_q;
  wire phaseBit = syncAccept ? 1'b0 : hbCnt_q;
  wire hbEmit = accept & (phaseBit == decPhase);
  wire signed [DW:0] sumI = DW'(prevI_q) + inI;
  wire signed [DW:0] sumQ = DW'(prevQ_q) + inQ;

  // Pair average keeps the top bits only; low bit dropped on purpose
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      hbCnt_q <= 1'b0;
      prevI_q <= '0;
      prevQ_q <= '0;
      hbI_q <= '0;
      hbQ_q <= '0;
      hbValid_q <= 1'b0;
    end
    else
    begin
      if (accept)
      begin
        hbCnt_q <= ~phaseBit;
        prevI_q <= inI;
        prevQ_q <= inQ;
      end
      else if (syncAccept)
        hbCnt_q <= 1'b0;
      hbValid_q <= hbEmit;
      if (hbEmit)
      begin
        hbI_q <= sumI[DW:1];
        hbQ_q <= sumQ[DW:1];
      end
    end
  end

  // ==========================================================================
  // Symmetric FIR, separate I and Q lines fed only by the half-band
  logic signed [DW-1:0] lineI_q [NTAP];
  logic signed [DW-1:0] lineQ_q [NTAP];
  logic lineValid_q;
  logic signed [PRODW-1:0] prodI [NHALF];
  logic signed [PRODW-1:0] prodQ [NHALF];
  logic signed [ACCW-1:0] accI;
  logic signed [ACCW-1:0] accQ;

  // Delay line shifts once per decimated sample
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      for (int k = 0; k < NTAP; k++)
      begin
        lineI_q[k] <= '0;
        lineQ_q[k] <= '0;
      end
      lineValid_q <= 1'b0;
    end
    else
    begin
      lineValid_q <= hbValid_q;
      if (hbValid_q)
      begin
        lineI_q[0] <= hbI_q;
        lineQ_q[0] <= hbQ_q;
        for (int k = 1; k < NTAP; k++)
        begin
          lineI_q[k] <= lineI_q[k-1];
          lineQ_q[k] <= lineQ_q[k-1];
        end
      end
    end
  end

  // Pre-add mirrored taps, then one multiplier per coefficient pair
  for (genvar k = 0; k < NHALF; k++)
  begin : g_tap
    wire signed [PREW-1:0] preI = PREW'(lineI_q[k]) + PREW'(lineI_q[NTAP-1-k]);
    wire signed [PREW-1:0] preQ = PREW'(lineQ_q[k]) + PREW'(lineQ_q[NTAP-1-k]);
    assign prodI[k] = preI * FIR_COEF[k];
    assign prodQ[k] = preQ * FIR_COEF[k];
  end

  // Sum of products
  always_comb
  begin
    accI = '0;
    accQ = '0;
    for (int k = 0; k < NHALF; k++)
    begin
      accI = accI + ACCW'(prodI[k]);
      accQ = accQ + ACCW'(prodQ[k]);
    end
  end

  // Round half up, then saturate; gain of the table is two to the FIR_SHIFT
  function automatic logic signed [DW-1:0] roundSat(input logic signed [ACCW-1:0] a);
    logic signed [ACCW-1:0] r;
    logic signed [ACCW-1:0] s;
    r = a + (ACCW'(1) <<< (FIR_SHIFT - 1));
    s = r >>> FIR_SHIFT;
    if (s > ACCW'(signed'({1'b0, {(DW-1){1'b1}}})))
      roundSat = {1'b0, {(DW-1){1'b1}}};
    else if (s < -(ACCW'(1) <<< (DW - 1)))
      roundSat = {1'b1, {(DW-1){1'b0}}};
    else
      roundSat = s[DW-1:0];
  endfunction

  // FIR or bypass; the half-band word still stands here
  logic signed [DW-1:0] firI_q;
  logic signed [DW-1:0] firQ_q;
  logic firValid_q;

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      firI_q <= '0;
      firQ_q <= '0;
      firValid_q <= 1'b0;
    end
    else
    begin
      firValid_q <= lineValid_q;
      if (lineValid_q)
      begin
        firI_q <= firEn ? roundSat(accI) : hbI_q;
        firQ_q <= firEn ? roundSat(accQ) : hbQ_q;
      end
    end
  end

  // ==========================================================================
  // Output FIFO; input stalls early enough to cover the pipeline in flight
  logic [$clog2(FIFO_DEPTH):0] fifoLevel;
  logic [2*DW-1:0] fifoRdData;
  logic fifoRdReady;

  ddc_fifo #(
    .W(2 * DW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .wrValid(firValid_q),
    .wrReady(fifoWrReady),
    .wrData({firI_q, firQ_q}),
    .rdValid(fifoRdValid),
    .rdReady(fifoRdReady),
    .rdData(fifoRdData),
    .level(fifoLevel)
  );

  // Back-pressure towards the source
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      inReady_q <= 1'b0;
    else
      inReady_q <= (fifoLevel < ($clog2(FIFO_DEPTH) + 1)'(FIFO_DEPTH - FIFO_SLACK));
  end
  assign inReady = inReady_q;

  // ==========================================================================
  // Final mixer and I/Q serialiser
  out_state_t outState_q;
  rot_t rot_q;
  logic signed [DW-1:0] heldQ_q;
  logic [DW-1:0] outData_q;
  logic outValid_q;
  logic outIsQ_q;

  wire signed [DW-1:0] popI = fifoRdData[2*DW-1:DW];
  wire signed [DW-1:0] popQ = fifoRdData[DW-1:0];
  wire canLoad = ~outValid_q | outReady;
  assign fifoRdReady = canLoad & (outState_q == OUT_FIRST);

  // Negation that cannot wrap the most negative code
  function automatic logic signed [DW-1:0] negSat(input logic signed [DW-1:0] x);
    negSat = (x == {1'b1, {(DW-1){1'b0}}}) ? {1'b0, {(DW-1){1'b1}}} : -x;
  endfunction

  // At the decimated rate fADC/8 is a quarter turn per output word
  wire signed [DW-1:0] mixOut =
    (rot_q == ROT_0) ? popI :
    (rot_q == ROT_90) ? negSat(popQ) :
    (rot_q == ROT_180) ? negSat(popI) : popQ;

  // Output register stage
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      outState_q <= OUT_FIRST;
      rot_q <= ROT_0;
      heldQ_q <= '0;
      outData_q <= '0;
      outValid_q <= 1'b0;
      outIsQ_q <= 1'b0;
    end
    else if (canLoad)
    begin
      case (outState_q)
        OUT_SECOND:
        begin
          outData_q <= heldQ_q;
          outIsQ_q <= 1'b1;
          outValid_q <= 1'b1;
          outState_q <= OUT_FIRST;
        end
        OUT_FIRST:
        begin
          outValid_q <= fifoRdValid;
          outIsQ_q <= 1'b0;
          if (fifoRdValid && mixEn)
          begin
            outData_q <= mixOut;
            rot_q <= rot_q + 2'h1;
          end
          else if (fifoRdValid)
          begin
            outData_q <= popI;
            heldQ_q <= popQ;
            outState_q <= OUT_SECOND;
          end
        end
        default:
          outState_q <= OUT_FIRST;
      endcase
    end
  end
  assign outData = outData_q;
  assign outValid = outValid_q;
  assign outIsQ = outIsQ_q;
endmodule

`default_nettype wire

//--- dv/ddc_monitor.sv
// Port checker for the downconverter back end
`timescale 1ns/10ps
`default_nettype none

// ============================================================================
// Checker
module ddc_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Configuration port
  input wire logic [ddc_pkg::AW-1:0] cfgAddr,
  input wire logic [ddc_pkg::RW-1:0] cfgWrData,
  input wire logic cfgWrStb,
  input wire logic cfgRdStb,
  input wire logic [ddc_pkg::RW-1:0] cfgRdData,
  // Stream
  input wire logic syncIn,
  input wire logic inReady,
  input wire logic outValid,
  input wire logic outReady,
  input wire logic [ddc_pkg::DW-1:0] outData,
  input wire logic outIsQ
);
  import ddc_pkg::*;
  logic mixOn_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Shadow of the mixer enable; pairs are only due while it is clear
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      mixOn_q <= 1'b0;
    else if (cfgWrStb && cfgAddr == ADDR_MIX_CTRL)
      mixOn_q <= cfgWrData[MIX_EN_BIT];
  end

  AST_INRDY: assert property ($rose(nrst) |-> ##[1:2] inReady)
    else $error("input not ready after reset");
  AST_HOLD: assert property (outValid && !outReady |=> outValid && $stable(outData) && $stable(outIsQ))
    else $error("output word moved while stalled");
  AST_PAIRQ: assert property (outValid && outReady && !outIsQ && !mixOn_q |=> outValid && outIsQ)
    else $error("Q word missing after I word");
  AST_QTHENI: assert property (outValid && outReady && outIsQ |=> !(outValid && outIsQ))
    else $error("two Q words in a row");
  AST_RDZERO: assert property ((!cfgRdStb ##1 1'b1) |-> cfgRdData == 8'h00)
    else $error("read data outside read slot");
  AST_UNMAP: assert property (cfgRdStb && cfgAddr == 12'h200 |=> cfgRdData == 8'h00)
    else $error("unmapped read not zero");
  AST_FIRRB: assert property (cfgWrStb && cfgAddr == ADDR_FIR_CTRL ##2 cfgRdStb && cfgAddr == ADDR_FIR_CTRL
    |=> cfgRdData == $past(cfgWrData, 3))
    else $error("filter enable readback wrong");
  AST_ARMED: assert property (cfgWrStb && cfgAddr == ADDR_SYNC_CTRL ##1 !syncIn
    ##1 cfgRdStb && cfgAddr == ADDR_STATUS && !syncIn |=> cfgRdData[ST_ARMED_BIT])
    else $error("write did not arm one-shot sync");
endmodule

bind ddc_fir_sync_final_mixer ddc_monitor u_mon (
  .ref_clk(ref_clk), .nrst(nrst), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData),
  .cfgWrStb(cfgWrStb), .cfgRdStb(cfgRdStb), .cfgRdData(cfgRdData), .syncIn(syncIn),
  .inReady(inReady), .outValid(outValid), .outReady(outReady), .outData(outData), .outIsQ(outIsQ)
);
`default_nettype wire

//--- dv/ddc_sink.sv
// Receiver model that takes the output stream
`timescale 1ns/10ps
`default_nettype none

// ============================================================================
// Sink
module ddc_sink (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Stall control
  input wire logic slow,
  input wire logic hold,
  // Stream
  input wire logic outValid,
  input wire logic outIsQ,
  input wire logic [15:0] outData,
  output logic outReady
);
  logic [16:0] got[$];
  logic [31:0] r = 32'h9d1;

  // Take words; stall at random when slow, fully when held
  always @(posedge ref_clk)
  begin
    if (nrst && outValid && outReady)
      got.push_back({outIsQ, outData});
    r <= {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
    outReady <= !hold && !(slow && r[3]);
  end
endmodule
`default_nettype wire

//--- dv/tb_ddc_fir_sync_final_mixer.sv
// Self-checking bench for the downconverter back end
`timescale 1ns/10ps
`default_nettype none

// ============================================================================
// Bench
module tb_ddc_fir_sync_final_mixer;
  import ddc_pkg::*;
  logic ref_clk = 0, nrst = 0, cfgWrStb = 0, cfgRdStb = 0, syncIn = 0, inValid = 0;
  logic slow = 0, hold = 0, outReady, outValid, inReady, outIsQ;
  logic [AW-1:0] cfgAddr = 0;
  logic [RW-1:0] cfgWrData = 0, cfgRdData;
  logic signed [DW-1:0] inI = 0, inQ = 0;
  logic [DW-1:0] outData;
  logic [31:0] lf = 32'd99157;
  int n_mismatch = 0, checks_done = 0;
  int sI[$], sQ[$];

  // Clock
  always #25 ref_clk = ~ref_clk;

  ddc_fir_sync_final_mixer DUT (.ref_clk(ref_clk), .nrst(nrst), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData),
    .cfgWrStb(cfgWrStb), .cfgRdStb(cfgRdStb), .cfgRdData(cfgRdData), .syncIn(syncIn), .inValid(inValid),
    .inReady(inReady), .inI(inI), .inQ(inQ), .outValid(outValid), .outReady(outReady), .outData(outData),
    .outIsQ(outIsQ));
  ddc_sink sink (.ref_clk(ref_clk), .nrst(nrst), .slow(slow), .hold(hold), .outValid(outValid),
    .outIsQ(outIsQ), .outData(outData), .outReady(outReady));

  // ==========================================================================
  // Expectation helpers
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] hb(int a, int b);
    int s;
    s = (a + b) >>> 1;
    return s[15:0];
  endfunction
  function automatic logic [15:0] ng(logic [15:0] v);
    return v == 16'h8000 ? 16'h7fff : -v;
  endfunction
  // Steady output for a constant input, saturated to the word width
  function automatic logic [15:0] fir(int x);
    longint acc;
    acc = 0;
    for (int k = 0; k < NHALF; k++)
      acc += longint'(FIR_COEF[k]) * 2 * x;
    acc = (acc + (64'sd1 <<< 20)) >>> 21;
    if (acc > 32767)
      acc = 32767;
    if (acc < -32768)
      acc = -32768;
    return acc[15:0];
  endfunction

  // ==========================================================================
  // Tasks
  task finish_test;
    $display("n_mismatch=%0d checks_done=%0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task tick;
    @(posedge ref_clk);
  endtask
  task guard(inout int t);
    t++;
    if (t > 3000)
    begin
      n_mismatch++;
      finish_test;
    end
    tick;
  endtask
  task rst;
    nrst <= 0;
    repeat (6) tick;
    sink.got.delete();
    sI.delete();
    sQ.delete();
    nrst <= 1;
    tick;
  endtask
  task wr(input logic [AW-1:0] a, input logic [RW-1:0] d);
    cfgAddr <= a;
    cfgWrData <= d;
    cfgWrStb <= 1;
    tick;
    cfgWrStb <= 0;
    tick;
  endtask
  task rd(input logic [AW-1:0] a, input logic [RW-1:0] e);
    cfgAddr <= a;
    cfgRdStb <= 1;
    tick;
    cfgRdStb <= 0;
    tick;
    chk(cfgRdData, e);
  endtask
  // Hold the sample until taken; random idle gap before it
  task send(input logic [15:0] i, input logic [15:0] q);
    int t;
    t = 0;
    lf = nx(lf);
    if (lf[0])
    begin
      inValid <= 0;
      tick;
    end
    inValid <= 1;
    inI <= i;
    inQ <= q;
    sI.push_back(int'(signed'(i)));
    sQ.push_back(int'(signed'(q)));
    tick;
    while (inReady !== 1'b1)
      guard(t);
  endtask
  task waitn(input int n);
    int t;
    t = 0;
    while (sink.got.size() < n)
      guard(t);
  endtask

  // Bypassed filter: decimation phase, sync restart, back-pressure
  task bypass(input int p);
    int t;
    t = 0;
    rst;
    rd(ADDR_FIR_CTRL, 8'h00);
    rd(ADDR_STATUS, 8'h02);
    wr(12'h200, 8'h5a);
    rd(12'h200, 8'h00);
    wr(ADDR_HB_CTRL, 8'(p << DEC_PHASE_BIT));
    wr(ADDR_SYNC_CTRL, 8'h20);
    // Odd sample first, so only a restart puts the phase back
    send(16'h1234, 16'h4321);
    inValid <= 0;
    repeat (12) tick;
    sink.got.delete();
    sI.delete();
    sQ.delete();
    syncIn <= 1;
    tick;
    syncIn <= 0;
    rd(ADDR_STATUS, 8'h02);
    // One-shot mode: a write arms, the next pulse is taken and disarms
    wr(ADDR_SYNC_CTRL, 8'h40);
    rd(ADDR_STATUS, 8'h03);
    syncIn <= 1;
    tick;
    syncIn <= 0;
    rd(ADDR_STATUS, 8'h02);
    hold <= 1;
    fork
      repeat (40)
      begin
        lf = nx(lf);
        send(lf[15:0], lf[31:16]);
      end
      begin
        while (inReady !== 1'b0)
          guard(t);
        chk(inReady, 0);
        rd(ADDR_STATUS, 8'h00);
        hold <= 0;
      end
    join
    inValid <= 0;
    waitn(40);
    for (int k = 1; k < 20; k++)
    begin
      chk(sink.got[2*k], {1'b0, hb(sI[2*k+p-1], sI[2*k+p])});
      chk(sink.got[2*k+1], {1'b1, hb(sQ[2*k+p-1], sQ[2*k+p])});
    end
    rd(ADDR_STATUS, 8'h02);
  endtask

  // Filter on, mixer on or off, constant input, slow sink
  task filt(input int m);
    logic [15:0] x, y, e;
    rst;
    wr(ADDR_FIR_CTRL, 8'h01);
    rd(ADDR_FIR_CTRL, 8'h01);
    wr(ADDR_MIX_CTRL, 8'(m));
    slow <= 1;
    lf = nx(lf);
    x = lf[15:0];
    y = lf[31:16];
    repeat (150) send(x, y);
    inValid <= 0;
    waitn(m ? 75 : 150);
    for (int k = 70; k < 75; k++)
    begin
      e = (k % 4 == 0) ? fir(int'(signed'(x))) : (k % 4 == 1) ? ng(fir(int'(signed'(y)))) :
        (k % 4 == 2) ? ng(fir(int'(signed'(x)))) : fir(int'(signed'(y)));
      if (m)
        chk(sink.got[k], {1'b0, e});
      else
      begin
        chk(sink.got[2*k], {1'b0, fir(int'(signed'(x)))});
        chk(sink.got[2*k+1], {1'b1, fir(int'(signed'(y)))});
      end
    end
    slow <= 0;
  endtask

  // Main sequence
  initial
  begin
    for (int p = 0; p < 2; p++)
      bypass(p);
    filt(0);
    filt(1);
    finish_test;
  end
endmodule
`default_nettype wire
